// >>> aloser_pkg.sv
// Constants shared by the serial output formatter.
`default_nettype none
package aloser_pkg;
    localparam int          SAMPLE_BITS       = 12;
    localparam int          BITS_TEN_X        = 10;
    localparam int          BITS_TWELVE_X     = 12;
    localparam int          FIFO_DEPTH        = 16;
    localparam logic [1:0]  PHASE_RESET       = 2'h2;
    localparam logic [1:0]  DATA_DELAY_RESET  = 2'h0;
    localparam logic [2:0]  CLOCK_DELAY_RESET = 3'h0;
    localparam logic [11:0] CODE_OB_POS_FULL  = 12'hFFF;
    localparam logic [11:0] CODE_OB_NEG_FULL  = 12'h000;
    localparam logic [11:0] CODE_TC_POS_FULL  = 12'h7FF;
    localparam logic [11:0] CODE_TC_NEG_FULL  = 12'h800;
    localparam logic [11:0] WORD_RESET        = 12'h000;
    localparam logic [3:0]  INDEX_RESET       = 4'h0;
    // Reset parks the bit index on the last bit so the first word starts whole.
    localparam logic [3:0]  INDEX_START_RESET = 4'hB;
endpackage
`default_nettype wire

// >>> aloser_properties.sv
// Port-level checks on the serial output formatter.
`default_nettype none
module aloser_properties (
    input wire logic       clk_in,
    input wire logic       rst_n_in,
    input wire logic       ten_x_mode_in,
    input wire logic [1:0] phase_select_in,
    input wire logic [1:0] data_delay_rise_code_in,
    input wire logic [1:0] data_delay_fall_code_in,
    input wire logic [2:0] clock_delay_rise_code_in,
    input wire logic [2:0] clock_delay_fall_code_in,
    input wire logic       serial_bit_clock_out,
    input wire logic       frame_clock_out,
    input wire logic [1:0] data_delay_rise_out,
    input wire logic [1:0] data_delay_fall_out,
    input wire logic [2:0] clock_delay_rise_code_out,
    input wire logic [2:0] clock_delay_fall_code_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    // ---------------------------------------------------------------
    // Settle counter: past values are trusted once it saturates.
    // ---------------------------------------------------------------
    logic [2:0] age_r;
    logic [2:0] age_nxt;
    logic       live;
    always_comb age_nxt = (age_r == 3'h7) ? age_r : age_r + 3'h1;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) age_r <= 3'h0;
        else age_r <= age_nxt;
    end
    assign live = (age_r == 3'h7);
    bclk_toggle_a: assert property (
        live && !$rose(frame_clock_out) |-> serial_bit_clock_out != $past(serial_bit_clock_out))
        else $error("bit clock missed a toggle");
    frame_ten_a: assert property (
        $rose(frame_clock_out) && ten_x_mode_in && $stable(ten_x_mode_in)
        |-> frame_clock_out[*5] ##1 !frame_clock_out[*5] ##1 frame_clock_out)
        else $error("ten bit frame shape wrong");
    frame_twelve_a: assert property (
        $rose(frame_clock_out) && !ten_x_mode_in && $stable(ten_x_mode_in)
        |-> frame_clock_out[*6] ##1 !frame_clock_out[*6] ##1 frame_clock_out)
        else $error("twelve bit frame shape wrong");
    frame_period_a: assert property (
        $rose(frame_clock_out) |-> ##[10:12] $rose(frame_clock_out))
        else $error("frame clock stopped");
    bclk_phase_a: assert property (
        $rose(frame_clock_out) && $stable(phase_select_in)
        |-> serial_bit_clock_out == (phase_select_in[0] ^ phase_select_in[1]))
        else $error("bit clock phase wrong at word start");
    data_delay_a: assert property (
        live |=> data_delay_rise_out == $past(data_delay_rise_code_in)
        && data_delay_fall_out == $past(data_delay_fall_code_in))
        else $error("data delay code not passed on");
    clock_delay_a: assert property (
        live |=> clock_delay_rise_code_out == $past(clock_delay_rise_code_in)
        && clock_delay_fall_code_out == $past(clock_delay_fall_code_in))
        else $error("clock delay code not passed on");
    delay_mode_a: assert property (
        live && $changed(ten_x_mode_in) |=> ##1 clock_delay_rise_code_out
        == $past(clock_delay_rise_code_in))
        else $error("delay code disturbed by mode change");
endmodule
`default_nettype wire

// >>> aloser_rx_model.sv
// Receiver model that rebuilds words from the serial lane.
`default_nettype none
module aloser_rx_model (
    input  wire logic  clk_in,
    input  wire logic  rst_n_in,
    input  wire logic  data_in,
    input  wire logic  frame_in,
    input  wire logic  ten_in,
    input  wire logic  msb_in,
    output logic [11:0] word_out,
    output logic        strobe_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // Deserializer aligned on frame clock rises.
    // ---------------------------------------------------------------
    logic [11:0] w;
    logic        f_q;
    logic        ten_q;
    logic        msb_q;
    int          k;
    always @(posedge clk_in) begin
        strobe_out <= 1'b0;
        if (!rst_n_in) k = 12;
        if (rst_n_in && frame_in && !f_q) begin
            k = 0;
            w = 12'h000;
            ten_q = ten_in;
            msb_q = msb_in;
        end
        if (k < (ten_q ? 10 : 12)) begin
            w[msb_q ? 11 - k : k + (ten_q ? 2 : 0)] = data_in;
            k++;
            if (k == (ten_q ? 10 : 12)) begin
                word_out   <= w;
                strobe_out <= 1'b1;
            end
        end
        f_q = frame_in;
    end
endmodule
`default_nettype wire

// >>> aloser_tb.sv
// Self-checking bench for the serial output formatter.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in, rst_n_in, sclk, valid, opos, oneg, ten, msb, tw, rdy;
    logic        sdat, bclk, fclk, stb, quiet;
    logic [11:0] din, rx_word, last;
    logic [1:0]  ph, ddr, ddf, ddr_o, ddf_o;
    logic [2:0]  cdr, cdf, cdr_o, cdf_o;
    logic [11:0] exp_q[$];
    int          num_errors, n_tests, cyc;
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    initial begin
        sclk = 1'b0;
        #37;
        forever #200 sclk = ~sclk;
    end
    aloser_top #(.DEPTH(4)) DUT (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .sample_clk_in(sclk),
        .sample_data_in(din), .sample_valid_in(valid), .over_pos_in(opos),
        .over_neg_in(oneg), .sample_ready_out(rdy), .ten_x_mode_in(ten),
        .msb_first_in(msb), .twos_complement_select_in(tw), .phase_select_in(ph),
        .data_delay_rise_code_in(ddr), .data_delay_fall_code_in(ddf),
        .clock_delay_rise_code_in(cdr), .clock_delay_fall_code_in(cdf),
        .serial_data_out(sdat), .serial_bit_clock_out(bclk), .frame_clock_out(fclk),
        .data_delay_rise_out(ddr_o), .data_delay_fall_out(ddf_o),
        .clock_delay_rise_code_out(cdr_o), .clock_delay_fall_code_out(cdf_o));
    aloser_rx_model u_rx (.clk_in(clk_in), .rst_n_in(rst_n_in), .data_in(sdat),
        .frame_in(fclk), .ten_in(ten), .msb_in(msb), .word_out(rx_word), .strobe_out(stb));
    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Mode changes garble the repeated word, so comparison pauses meanwhile.
    task automatic cfg(input logic t, input logic m, input logic c);
        quiet = 1'b1;
        ten = t;
        msb = m;
        tw = c;
        repeat (40) @(posedge clk_in);
        #1;
        last = rx_word;
        quiet = 1'b0;
    endtask
    task automatic put(input logic [11:0] d, input logic p, input logic n);
        logic [11:0] e;
        e = p ? (tw ? 12'h7FF : 12'hFFF) : n ? (tw ? 12'h800 : 12'h000) : {d[11] ^ tw, d[10:0]};
        exp_q.push_back(ten ? (e & 12'hFFC) : e);
        @(negedge sclk);
        @(posedge clk_in);
        #1;
        din = d;
        opos = p;
        oneg = n;
        valid = 1'b1;
        @(posedge sclk);
        repeat (5) @(posedge clk_in);
        #1;
        valid = 1'b0;
    endtask
    task automatic drain();
        repeat (300) begin
            @(posedge clk_in);
            #1;
            if (exp_q.size() == 0) break;
        end
        chk({11'h0, exp_q.size() != 0}, 12'h000);
    endtask
    always @(posedge clk_in) begin
        if (stb && !quiet && rx_word !== last) begin
            last = rx_word;
            chk(rx_word, exp_q.pop_front());
        end
    end
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            stop_test();
        end
    end
    // ---------------------------------------------------------------
    // Test sequence
    // ---------------------------------------------------------------
    initial begin
        rst_n_in = 1'b0;
        {valid, opos, oneg, ten, tw, din, ddr, ddf, cdr, cdf, last} = '0;
        msb = 1'b1;
        ph = 2'h2;
        quiet = 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
        chk({9'h0, rdy, sdat, fclk}, 12'h000);
        @(posedge clk_in);
        #1;
        rst_n_in = 1'b1;
        @(posedge fclk);
        #1;
        chk({11'h0, bclk}, 12'h001);
        $display("Test reset finished");
        for (int m = 0; m < 4; m++) begin
            cfg(m[1], m[0], 1'b0);
            put(12'hC35, 1'b0, 1'b0);
            put(12'h3A9, 1'b0, 1'b0);
            drain();
        end
        $display("Test modes finished");
        cfg(1'b0, 1'b1, 1'b1);
        put(12'h123, 1'b0, 1'b0);
        put(12'h123, 1'b1, 1'b0);
        put(12'h123, 1'b0, 1'b1);
        put(12'h123, 1'b1, 1'b1);
        drain();
        cfg(1'b0, 1'b1, 1'b0);
        put(12'h456, 1'b0, 1'b0);
        put(12'h456, 1'b1, 1'b0);
        put(12'hFFF, 1'b0, 1'b1);
        drain();
        $display("Test format finished");
        for (int i = 0; i < 8; i++) begin
            ph = i[1:0];
            ddr = i[1:0];
            ddf = ~i[1:0];
            cdr = i[2:0];
            cdf = ~i[2:0];
            cfg(i[2], i[0], 1'b0);
            @(posedge fclk);
            #1;
            chk({11'h0, bclk}, {11'h0, i[0] ^ i[1]});
            chk({2'h0, ddr_o, ddf_o, cdr_o, cdf_o},
                {2'h0, i[1:0], ~i[1:0], i[2:0], ~i[2:0]});
        end
        $display("Test phase and delay finished");
        cfg(1'b0, 1'b1, 1'b0);
        exp_q.push_back(12'h6C5);
        {opos, oneg} = 2'b00;
        din = 12'h6C5;
        valid = 1'b1;
        repeat (600) begin
            @(posedge clk_in);
            #1;
            if (!rdy) break;
        end
        chk({11'h0, rdy}, 12'h000);
        repeat (40) @(posedge clk_in);
        #1;
        valid = 1'b0;
        repeat (300) @(posedge clk_in);
        #1;
        chk({11'h0, rdy}, 12'h001);
        chk(last, 12'h6C5);
        $display("Test fill and drain finished");
        stop_test();
    end
endmodule
bind aloser_top aloser_properties u_props (.*);
`default_nettype wire

// >>> aloser_top.sv
// Sample FIFO and serial lane formatter with bit and frame clocks.
`default_nettype none

// ---------------------------------------------------------------------
// Sample FIFO
// ---------------------------------------------------------------------
module aloser_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // Fill side
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    // Drain side
    output logic                  out_valid_out,
    output logic [WIDTH-1:0]      out_data_out,
    input  wire logic             out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] mem_nxt [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    wr_ptr_nxt;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW-1:0]    rd_ptr_nxt;
    logic [CW-1:0]    count_r;
    logic [CW-1:0]    count_nxt;
    logic             ready_r;
    logic             ready_nxt;
    logic             push;
    logic             pop;

    always_comb begin
        push       = in_valid_in && ready_r;
        pop        = out_ready_in && (count_r != '0);
        mem_nxt    = mem_r;
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        count_nxt  = count_r;
        if (push) begin
            mem_nxt[wr_ptr_r] = in_data_in;
            wr_ptr_nxt        = (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
        end
        if (pop) begin
            rd_ptr_nxt = (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
        end
        if (push && !pop) begin
            count_nxt = count_r + 1'b1;
        end else if (pop && !push) begin
            count_nxt = count_r - 1'b1;
        end
        // Ready is registered, so full is judged on the next count.
        ready_nxt = (count_nxt != CW'(DEPTH));
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
            ready_r  <= 1'b0;
        end else begin
            mem_r    <= mem_nxt;
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r  <= count_nxt;
            ready_r  <= ready_nxt;
        end
    end

    assign in_ready_out  = ready_r;
    assign out_valid_out = (count_r != '0);
    assign out_data_out  = mem_r[rd_ptr_r];
endmodule

// ---------------------------------------------------------------------
// Top level
// ---------------------------------------------------------------------
module aloser_top
    import aloser_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // Converter sample clock, asynchronous to clk_in
    input  wire logic        sample_clk_in,
    // Converter result, offset binary, with overdrive flags
    input  wire logic [11:0] sample_data_in,
    input  wire logic        sample_valid_in,
    input  wire logic        over_pos_in,
    input  wire logic        over_neg_in,
    output logic             sample_ready_out,
    // Configuration
    input  wire logic        ten_x_mode_in,
    input  wire logic        msb_first_in,
    input  wire logic        twos_complement_select_in,
    input  wire logic [1:0]  phase_select_in,
    input  wire logic [1:0]  data_delay_rise_code_in,
    input  wire logic [1:0]  data_delay_fall_code_in,
    input  wire logic [2:0]  clock_delay_rise_code_in,
    input  wire logic [2:0]  clock_delay_fall_code_in,
    // Serial link
    output logic             serial_data_out,
    output logic             serial_bit_clock_out,
    output logic             frame_clock_out,
    // Delay codes handed to the output pad trims
    output logic [1:0]       data_delay_rise_out,
    output logic [1:0]       data_delay_fall_out,
    output logic [2:0]       clock_delay_rise_code_out,
    output logic [2:0]       clock_delay_fall_code_out
);
    // -----------------------------------------------------------------
    // Functions
    // -----------------------------------------------------------------
    // Output code for one sample in the selected format.
    function automatic logic [11:0] format_code(input logic [11:0] raw, input logic tc,
                                                input logic pos, input logic neg);
        logic [11:0] code;
        code = tc ? {~raw[11], raw[10:0]} : raw;
        if (pos) begin
            code = tc ? CODE_TC_POS_FULL : CODE_OB_POS_FULL;
        end else if (neg) begin
            code = tc ? CODE_TC_NEG_FULL : CODE_OB_NEG_FULL;
        end
        return code;
    endfunction

    // Bit sent at position idx of a word, in the chosen order and width.
    function automatic logic pick_bit(input logic [11:0] w, input logic [3:0] idx,
                                      input logic ten, input logic msb);
        logic [3:0] pos;
        pos = 4'hF;
        if (msb) begin
            pos = 4'(11 - int'(idx));
        end else if (ten) begin
            pos = 4'(2 + int'(idx));
        end else begin
            pos = idx;
        end
        return w[pos];
    endfunction

    // -----------------------------------------------------------------
    // Reset release and sample clock synchroniser
    // -----------------------------------------------------------------
    logic       rst_meta_r;
    logic       rst_sync_r;
    logic       sclk_meta_r;
    logic       sclk_sync_r;
    logic       sclk_prev_r;
    logic       sample_edge;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    always_ff @(posedge clk_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            sclk_meta_r <= 1'b0;
            sclk_sync_r <= 1'b0;
            sclk_prev_r <= 1'b0;
        end else begin
            sclk_meta_r <= sample_clk_in;
            sclk_sync_r <= sclk_meta_r;
            sclk_prev_r <= sclk_sync_r;
        end
    end

    assign sample_edge = sclk_sync_r && !sclk_prev_r;

    // -----------------------------------------------------------------
    // Sample capture into the FIFO
    // -----------------------------------------------------------------
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic [11:0] fifo_out_data;
    logic        fifo_pop;
    logic        capture;
    logic [11:0] captured_code;

    // A sample is taken on each sample clock rising edge with sample_valid_in high while room remains.
    assign capture       = sample_edge && sample_valid_in;
    assign captured_code = format_code(sample_data_in, twos_complement_select_in,
                                       over_pos_in, over_neg_in);

    aloser_fifo #(
        .WIDTH (SAMPLE_BITS),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_in        (clk_in),
        .rst_n_in      (rst_sync_r),
        .in_valid_in   (capture),
        .in_data_in    (captured_code),
        .in_ready_out  (fifo_in_ready),
        .out_valid_out (fifo_out_valid),
        .out_data_out  (fifo_out_data),
        .out_ready_in  (fifo_pop)
    );

    // -----------------------------------------------------------------
    // Serializer
    // -----------------------------------------------------------------
    logic [11:0] word_r;
    logic [11:0] word_nxt;
    logic [3:0]  idx_r;
    logic [3:0]  idx_nxt;
    logic        ten_r;
    logic        ten_nxt;
    logic        msb_r;
    logic        msb_nxt;
    logic [1:0]  phase_r;
    logic [1:0]  phase_nxt;
    logic        data_r;
    logic        data_nxt;
    logic        bclk_r;
    logic        bclk_nxt;
    logic        fclk_r;
    logic        fclk_nxt;
    logic        ready_r;
    logic        ready_nxt;
    logic [1:0]  ddr_r;
    logic [1:0]  ddf_r;
    logic [2:0]  cdr_r;
    logic [2:0]  cdf_r;
    logic [3:0]  last_idx;
    logic        frame_start;
    logic [3:0]  word_bits;
    logic [11:0] send_word;
    logic        send_ten;
    logic        send_msb;
    logic [1:0]  send_phase;

    always_comb begin
        last_idx    = ten_r ? 4'(BITS_TEN_X - 1) : 4'(BITS_TWELVE_X - 1);
        frame_start = (idx_r == last_idx);
        fifo_pop    = frame_start && fifo_out_valid;
        word_nxt    = word_r;
        ten_nxt     = ten_r;
        msb_nxt     = msb_r;
        phase_nxt   = phase_r;
        idx_nxt     = idx_r + 1'b1;
        if (frame_start) begin
            // Settings are latched only at word boundaries; an empty FIFO
            // repeats the last word so the link keeps its framing.
            idx_nxt   = INDEX_RESET;
            ten_nxt   = ten_x_mode_in;
            msb_nxt   = msb_first_in;
            phase_nxt = phase_select_in;
            if (fifo_out_valid) begin
                word_nxt = fifo_out_data;
            end
        end
        send_word  = word_nxt;
        send_ten   = ten_nxt;
        send_msb   = msb_nxt;
        send_phase = phase_nxt;
        word_bits  = send_ten ? 4'(BITS_TEN_X) : 4'(BITS_TWELVE_X);
        data_nxt   = pick_bit(send_word, idx_nxt, send_ten, send_msb);
        // One bit per clock; the bit clock toggles every bit except at a word start that flips the phase parity, giving N/2
        // periods per word. Phase bit 0 inverts, bit 1 swaps edge order.
        bclk_nxt   = ~idx_nxt[0] ^ send_phase[0] ^ ~send_phase[1];
        fclk_nxt   = (idx_nxt < (word_bits >> 1));
        ready_nxt  = fifo_in_ready;
    end

    always_ff @(posedge clk_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            word_r  <= WORD_RESET;
            idx_r   <= INDEX_START_RESET;
            ten_r   <= 1'b0;
            msb_r   <= 1'b1;
            phase_r <= PHASE_RESET;
            data_r  <= 1'b0;
            bclk_r  <= 1'b0;
            fclk_r  <= 1'b0;
            ready_r <= 1'b0;
        end else begin
            word_r  <= word_nxt;
            idx_r   <= idx_nxt;
            ten_r   <= ten_nxt;
            msb_r   <= msb_nxt;
            phase_r <= phase_nxt;
            data_r  <= data_nxt;
            bclk_r  <= bclk_nxt;
            fclk_r  <= fclk_nxt;
            ready_r <= ready_nxt;
        end
    end

    // -----------------------------------------------------------------
    // Delay codes, same meaning in both serialization modes
    // -----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            ddr_r <= DATA_DELAY_RESET;
            ddf_r <= DATA_DELAY_RESET;
            cdr_r <= CLOCK_DELAY_RESET;
            cdf_r <= CLOCK_DELAY_RESET;
        end else begin
            ddr_r <= data_delay_rise_code_in;
            ddf_r <= data_delay_fall_code_in;
            cdr_r <= clock_delay_rise_code_in;
            cdf_r <= clock_delay_fall_code_in;
        end
    end

    assign sample_ready_out          = ready_r;
    assign serial_data_out           = data_r;
    assign serial_bit_clock_out      = bclk_r;
    assign frame_clock_out           = fclk_r;
    assign data_delay_rise_out       = ddr_r;
    assign data_delay_fall_out       = ddf_r;
    assign clock_delay_rise_code_out = cdr_r;
    assign clock_delay_fall_code_out = cdf_r;
endmodule
`default_nettype wire
